// >>> pei_event_status.sv
// PHY event status and enable register with its AHB-Lite slave, the
// system interrupt and the shared interrupt / power-down pin.
// Assumes event sources and counters run on sys_clk; the pin is async.
`timescale 1ns/10ps
`default_nettype none

module pei_event_status #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pei_pkg::pei_link_state_t linkState,
  input wire logic [CNT_W-1:0] falseCarrierCount,
  input wire logic [CNT_W-1:0] receiveErrorCount,
  output logic irq,
  input wire logic intPdPinIn,
  output logic intPdPinOut,
  output logic intPdPinOe,
  output logic powerDownReq
);

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  pei_pkg::pei_link_state_t prevState_q, prevState_d;
  logic prevFcHalf_q, prevFcHalf_d;
  logic prevReHalf_q, prevReHalf_d;
  logic primed_q, primed_d;
  logic [pei_pkg::NUM_EVT-1:0] evt;

  // Primed flag keeps the first cycle after reset from faking changes
  always_comb begin
    prevState_d = linkState;
    prevFcHalf_d = falseCarrierCount[CNT_W-1];
    prevReHalf_d = receiveErrorCount[CNT_W-1];
    primed_d = 1'b1;
    evt = '0;
    evt[pei_pkg::EVT_LQ] = primed_q & linkState.linkUp & prevState_q.linkUp &
      (linkState.linkQualityGood != prevState_q.linkQualityGood);
    evt[pei_pkg::EVT_ED] = primed_q &
      (linkState.energyDetected != prevState_q.energyDetected);
    evt[pei_pkg::EVT_LS] = primed_q & (linkState.linkUp != prevState_q.linkUp);
    evt[pei_pkg::EVT_SPD] = primed_q & (linkState.speed100 != prevState_q.speed100);
    evt[pei_pkg::EVT_DUP] = primed_q & (linkState.fullDuplex != prevState_q.fullDuplex);
    evt[pei_pkg::EVT_AN] = primed_q & linkState.anComplete & ~prevState_q.anComplete;
    evt[pei_pkg::EVT_FC] = primed_q & falseCarrierCount[CNT_W-1] & ~prevFcHalf_q;
    evt[pei_pkg::EVT_RE] = primed_q & receiveErrorCount[CNT_W-1] & ~prevReHalf_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevState_q <= '0;
      prevFcHalf_q <= 1'b0;
      prevReHalf_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      prevState_q <= prevState_d;
      prevFcHalf_q <= prevFcHalf_d;
      prevReHalf_q <= prevReHalf_d;
      primed_q <= primed_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  pei_pkg::pei_aphase_t aph_q, aph_d;
  logic take;
  logic [7:0] takeIdx;
  logic addrInRange;
  logic rdClr;
  logic dataWr;

  assign take = hsel & hready & htrans[1];
  assign addrInRange = (haddr[31:10] == 22'h000000);
  assign takeIdx = addrInRange ? haddr[9:2] : 8'hFF;
  assign rdClr = take & ~hwrite & (takeIdx == pei_pkg::IDX_EVT);
  assign dataWr = aph_q.valid & aph_q.write;

  always_comb begin
    aph_d.valid = take;
    aph_d.write = hwrite;
    aph_d.idx = takeIdx;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aph_q <= '0;
    end else begin
      aph_q <= aph_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [pei_pkg::NUM_EVT-1:0] latch_q, latch_d;
  logic [pei_pkg::NUM_EVT-1:0] irqStat_q, irqStat_d;
  logic [pei_pkg::NUM_EVT-1:0] irqEn_q, irqEn_d;
  logic [pei_pkg::EN_MSB-pei_pkg::EN_LSB:0] evtEn_q, evtEn_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [pei_pkg::NUM_EVT-1:0] irqClr;

  // Set wins over clear on every flag
  for (genvar i = 0; i < pei_pkg::NUM_EVT; i++) begin : g_evt
    assign latch_d[i] = evt[i] | (latch_q[i] & ~rdClr);
    assign irqStat_d[i] = evt[i] | (irqStat_q[i] & ~irqClr[i]);
  end

  assign irqClr = (dataWr && aph_q.idx == pei_pkg::IDX_IRQ_CLR) ?
    hwdata[pei_pkg::NUM_EVT-1:0] : '0;

  always_comb begin
    evtEn_d = evtEn_q;
    ctrl_d = ctrl_q;
    irqEn_d = irqEn_q;
    if (dataWr) begin
      unique case (aph_q.idx)
        pei_pkg::IDX_EVT: begin
          evtEn_d = hwdata[pei_pkg::EN_MSB:pei_pkg::EN_LSB];
        end
        pei_pkg::IDX_CTRL: begin
          ctrl_d = hwdata[2:0];
        end
        pei_pkg::IDX_IRQ_EN: begin
          irqEn_d = hwdata[pei_pkg::NUM_EVT-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_q <= pei_pkg::EVT_RST;
      irqStat_q <= pei_pkg::EVT_RST;
      irqEn_q <= pei_pkg::IRQ_EN_RST;
      evtEn_q <= pei_pkg::EN_RST;
      ctrl_q <= pei_pkg::CTRL_RST;
    end else begin
      latch_q <= latch_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
      evtEn_q <= evtEn_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Sampled at the address edge, forwarding a write in its data phase,
  // so a read straight after a write sees the new value, except IDX_IRQ_STAT read straight after an IDX_IRQ_CLR write.
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (take && !hwrite) begin
      unique case (takeIdx)
        pei_pkg::IDX_EVT: begin
          rdata_d[pei_pkg::EVT_LSB +: pei_pkg::NUM_EVT] = latch_q;
          rdata_d[pei_pkg::EN_MSB:pei_pkg::EN_LSB] = evtEn_d;
        end
        pei_pkg::IDX_CTRL: begin
          rdata_d[2:0] = ctrl_d;
        end
        pei_pkg::IDX_FC_CNT: begin
          rdata_d[CNT_W-1:0] = falseCarrierCount;
        end
        pei_pkg::IDX_RE_CNT: begin
          rdata_d[CNT_W-1:0] = receiveErrorCount;
        end
        pei_pkg::IDX_IRQ_STAT: begin
          rdata_d[pei_pkg::NUM_EVT-1:0] = irqStat_q;
        end
        pei_pkg::IDX_IRQ_EN: begin
          rdata_d[pei_pkg::NUM_EVT-1:0] = irqEn_d;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Interrupt outputs and shared pin
  // ----------------------------------------------------------------
  logic pinPending;
  logic pinOut_q, pinOut_d;
  logic irq_q, irq_d;
  logic [2:0] pinSync_q, pinSync_d;
  logic pinLvl_q, pinLvl_d;
  logic pwrDown_q, pwrDown_d;

  // Only bits 7..5 have enables here; the other events never reach the pin
  assign pinPending = (ctrl_q[pei_pkg::CTRL_GLOBAL_EN] &
    (|(latch_q[pei_pkg::EN_MSB:pei_pkg::EN_LSB] & evtEn_q))) |
    ctrl_q[pei_pkg::CTRL_TEST_INT];

  always_comb begin
    pinOut_d = ~pinPending;
    irq_d = |(irqStat_q & irqEn_q);
    pinSync_d = {pinSync_q[1:0], intPdPinIn};
    pinLvl_d = (pinSync_q[1] == pinSync_q[2]) ? pinSync_q[2] : pinLvl_q;
    pwrDown_d = ~ctrl_q[pei_pkg::CTRL_OUT_EN] & ~pinLvl_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut_q <= 1'b1;
      irq_q <= 1'b0;
      pinSync_q <= 3'h7;
      pinLvl_q <= 1'b1;
      pwrDown_q <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
      irq_q <= irq_d;
      pinSync_q <= pinSync_d;
      pinLvl_q <= pinLvl_d;
      pwrDown_q <= pwrDown_d;
    end
  end

  assign intPdPinOut = pinOut_q;
  assign intPdPinOe = ctrl_q[pei_pkg::CTRL_OUT_EN];
  assign irq = irq_q;
  assign powerDownReq = pwrDown_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_lq_latch: assert property (primed_q && linkState.linkUp && $past(linkState.linkUp)
    && linkState.linkQualityGood != $past(linkState.linkQualityGood) && primed_q
    && $past(primed_q) |=> latch_q[pei_pkg::EVT_LQ])
    else $error("link quality change not latched");

  chk_ed_latch: assert property ($past(primed_q) && $changed(linkState.energyDetected)
    |=> latch_q[pei_pkg::EVT_ED])
    else $error("energy detect change not latched");

  chk_ls_latch: assert property ($past(primed_q) && $changed(linkState.linkUp)
    |=> latch_q[pei_pkg::EVT_LS] && irqStat_q[pei_pkg::EVT_LS])
    else $error("link status change not latched");

  chk_spd_latch: assert property ($past(primed_q) && $changed(linkState.speed100)
    |=> latch_q[pei_pkg::EVT_SPD])
    else $error("speed change not latched");

  chk_dup_latch: assert property ($past(primed_q) && $changed(linkState.fullDuplex)
    |=> latch_q[pei_pkg::EVT_DUP])
    else $error("duplex change not latched");

  chk_an_latch: assert property ($past(primed_q) && $rose(linkState.anComplete)
    |=> latch_q[pei_pkg::EVT_AN])
    else $error("autoneg completion not latched");

  chk_fc_half: assert property ($past(primed_q) && $rose(falseCarrierCount[CNT_W-1])
    |=> latch_q[pei_pkg::EVT_FC])
    else $error("false carrier half full not latched");

  chk_re_half: assert property ($past(primed_q) && $rose(receiveErrorCount[CNT_W-1])
    |=> latch_q[pei_pkg::EVT_RE])
    else $error("receive error half full not latched");

  chk_enable_write: assert property (dataWr && aph_q.idx == pei_pkg::IDX_EVT
    |=> evtEn_q == $past(hwdata[pei_pkg::EN_MSB:pei_pkg::EN_LSB]))
    else $error("event enables not written");

  chk_global_gate: assert property (!ctrl_q[pei_pkg::CTRL_GLOBAL_EN]
    && !ctrl_q[pei_pkg::CTRL_TEST_INT] |=> intPdPinOut)
    else $error("pin interrupt without global enable");

  chk_pin_drive: assert property (ctrl_q[pei_pkg::CTRL_GLOBAL_EN]
    && (latch_q[pei_pkg::EVT_LS] && evtEn_q[pei_pkg::EVT_LS-pei_pkg::EN_LSB])
    && ctrl_q[pei_pkg::CTRL_OUT_EN]
    && !(dataWr && aph_q.idx == pei_pkg::IDX_CTRL) |=> !intPdPinOut && intPdPinOe)
    else $error("pin not driven low on enabled event");

  chk_read_clear: assert property (rdClr |=> latch_q == $past(evt)
    && hrdata[pei_pkg::EVT_LSB +: pei_pkg::NUM_EVT] == $past(latch_q))
    else $error("read did not return and clear latched bits");

  chk_latch_hold: assert property (!rdClr
    |=> latch_q == ($past(latch_q) | $past(evt)))
    else $error("latched bits changed without a read");

  chk_enable_hold: assert property (!dataWr
    || aph_q.idx != pei_pkg::IDX_EVT |=> $stable(evtEn_q))
    else $error("event enables changed without a write");

  chk_test_force: assert property (ctrl_q[pei_pkg::CTRL_TEST_INT] |=> !intPdPinOut)
    else $error("test interrupt did not drive the pin low");

  chk_power_down: assert property (!ctrl_q[pei_pkg::CTRL_OUT_EN] && !pinLvl_q
    |=> powerDownReq)
    else $error("low pin did not request power down");

  chk_irq_level: assert property (|(irqStat_q & irqEn_q) |=> irq)
    else $error("enabled status bit did not raise irq");

endmodule

`default_nettype wire

// >>> pei_mgmt_model.sv
// Management controller model: AHB-Lite master, single word transfers.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/10ps
`default_nettype none
module pei_mgmt_model (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int hung = 0;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ------------------------------------------------------------
  // Bounded wait: never trusts a fixed slave latency
  // ------------------------------------------------------------
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) hung++;
  endtask

  // Call right after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// >>> pei_pkg.sv
// Package for the PHY event status block: register indices, field
// positions, reset values and the carrier types.
// Assumes a word-wide AHB-Lite slave where byte address = index * 4.
package pei_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h11;
  localparam logic [7:0] IDX_EVT = 8'h12;
  localparam logic [7:0] IDX_FC_CNT = 8'h14;
  localparam logic [7:0] IDX_RE_CNT = 8'h15;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h21;
  localparam logic [7:0] IDX_IRQ_EN = 8'h22;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_EVT = 8;
  localparam int EVT_LSB = 8;
  localparam int EVT_LQ = 7;
  localparam int EVT_ED = 6;
  localparam int EVT_LS = 5;
  localparam int EVT_SPD = 4;
  localparam int EVT_DUP = 3;
  localparam int EVT_AN = 2;
  localparam int EVT_FC = 1;
  localparam int EVT_RE = 0;
  localparam int EN_MSB = 7;
  localparam int EN_LSB = 5;
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_GLOBAL_EN = 1;
  localparam int CTRL_TEST_INT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_EVT-1:0] EVT_RST = 8'h00;
  localparam logic [EN_MSB-EN_LSB:0] EN_RST = 3'h0;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [NUM_EVT-1:0] IRQ_EN_RST = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic linkUp;
    logic linkQualityGood;
    logic energyDetected;
    logic speed100;
    logic fullDuplex;
    logic anComplete;
  } pei_link_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } pei_aphase_t;

endpackage

// >>> phy_event_interrupt_status_tb_top.sv
// Testbench for the PHY event status block.
// Assumes the management model is the only bus master; pin pulled up.
`timescale 1ns/10ps
`default_nettype none
module phy_event_interrupt_status_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, irq, intPdPinOut, intPdPinOe, powerDownReq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic intPdPinIn = 1'b1;
  pei_pkg::pei_link_state_t linkState = '0;
  logic [15:0] falseCarrierCount = 16'h0000;
  logic [15:0] receiveErrorCount = 16'h0000;
  logic [15:0] lfsr = 16'hD0DF;
  int errorCnt = 0;
  int numChecks = 0;
  int i;

  pei_event_status i_pei_event_status (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .linkState,
    .falseCarrierCount, .receiveErrorCount, .irq, .intPdPinIn, .intPdPinOut,
    .intPdPinOe, .powerDownReq);

  pei_mgmt_model i_pei_mgmt_model (.sys_clk, .hready(hreadyout), .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata);

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] nextRand(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Quality change only counts while the link stays up
  function automatic logic [7:0] expEvt(input int k);
    if (k == pei_pkg::EVT_LQ && linkState.linkUp !== 1'b1) return 8'h00;
    return 8'(1 << k);
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    i_pei_mgmt_model.xfer(1'b0, {22'h0, idx, 2'h0}, 32'h0, rd);
    cmp(what, exp, rd);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    i_pei_mgmt_model.xfer(1'b1, {22'h0, idx, 2'h0}, d, rd);
  endtask

  // Re-arms edge-type sources first so every event fires again, except a quality change while the link is down
  task automatic fire(input int k);
    @(posedge sys_clk);
    lfsr = nextRand(lfsr);
    linkState.anComplete <= 1'b0;
    falseCarrierCount <= {1'b0, lfsr[14:0]};
    receiveErrorCount <= {1'b0, lfsr[15:1]};
    @(posedge sys_clk);
    case (k)
      pei_pkg::EVT_LQ: linkState.linkQualityGood <= ~linkState.linkQualityGood;
      pei_pkg::EVT_ED: linkState.energyDetected <= ~linkState.energyDetected;
      pei_pkg::EVT_LS: linkState.linkUp <= ~linkState.linkUp;
      pei_pkg::EVT_SPD: linkState.speed100 <= ~linkState.speed100;
      pei_pkg::EVT_DUP: linkState.fullDuplex <= ~linkState.fullDuplex;
      pei_pkg::EVT_AN: linkState.anComplete <= 1'b1;
      pei_pkg::EVT_FC: falseCarrierCount <= {1'b1, lfsr[14:0]};
      default: receiveErrorCount <= {1'b1, lfsr[15:1]};
    endcase
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic tally_and_finish();
    errorCnt += i_pei_mgmt_model.hung;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmp("irq", 32'h0, {31'h0, irq});
    cmp("pin oe", 32'h0, {31'h0, intPdPinOe});
    cmp("pin out", 32'h1, {31'h0, intPdPinOut});
    rdChk(pei_pkg::IDX_EVT, 32'h0, "evt reset");
    rdChk(pei_pkg::IDX_CTRL, 32'h0, "ctrl reset");
    rdChk(pei_pkg::IDX_IRQ_EN, 32'h0, "irq en reset");
    rdChk(8'hF0, 32'h0, "unmapped");
    cmp("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    wr(pei_pkg::IDX_EVT, 32'hFFFF_FFFF);
    rdChk(pei_pkg::IDX_EVT, 32'h0000_00E0, "evt enables");
    wr(pei_pkg::IDX_EVT, 32'h0);
    rdChk(pei_pkg::IDX_EVT, 32'h0, "evt enables off");
    $display("test enables done");
    fire(pei_pkg::EVT_LS);
    rdChk(pei_pkg::IDX_EVT, 32'h2000, "link up");
    wr(pei_pkg::IDX_IRQ_CLR, 32'hFF);
    // Each event in order, then a random mix
    for (int it = 0; it < 24; it++) begin
      lfsr = nextRand(lfsr);
      i = (it < 8) ? 7 - it : int'(lfsr[2:0]);
      fire(i);
      rdChk(pei_pkg::IDX_EVT, {16'h0, expEvt(i), 8'h00}, "evt latch");
      rdChk(pei_pkg::IDX_EVT, 32'h0, "evt cleared");
      rdChk(pei_pkg::IDX_IRQ_STAT, {24'h0, expEvt(i)}, "irq stat");
      rdChk(pei_pkg::IDX_FC_CNT, {16'h0, falseCarrierCount}, "fc count");
      rdChk(pei_pkg::IDX_RE_CNT, {16'h0, receiveErrorCount}, "re count");
      wr(pei_pkg::IDX_IRQ_CLR, 32'hFF);
    end
    $display("test events done");
    wr(pei_pkg::IDX_IRQ_EN, 32'h20);
    fire(pei_pkg::EVT_LS);
    cmp("irq raised", 32'h1, {31'h0, irq});
    wr(pei_pkg::IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(pei_pkg::IDX_IRQ_EN, 32'h20);
    repeat (2) @(posedge sys_clk);
    cmp("irq unmasked", 32'h1, {31'h0, irq});
    wr(pei_pkg::IDX_IRQ_CLR, 32'hFF);
    repeat (2) @(posedge sys_clk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");
    wr(pei_pkg::IDX_CTRL, 32'h1);
    wr(pei_pkg::IDX_EVT, 32'h20);
    rdChk(pei_pkg::IDX_EVT, 32'h2020, "stale latch");
    fire(pei_pkg::EVT_LS);
    cmp("pin no global", 32'h1, {31'h0, intPdPinOut});
    rdChk(pei_pkg::IDX_EVT, 32'h2020, "evt ls");
    wr(pei_pkg::IDX_CTRL, 32'h3);
    fire(pei_pkg::EVT_LS);
    cmp("pin oe on", 32'h1, {31'h0, intPdPinOe});
    cmp("pin active", 32'h0, {31'h0, intPdPinOut});
    wr(pei_pkg::IDX_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk);
    cmp("pin oe off", 32'h0, {31'h0, intPdPinOe});
    cmp("power down", 32'h0, {31'h0, powerDownReq});
    intPdPinIn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cmp("power down req", 32'h1, {31'h0, powerDownReq});
    intPdPinIn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmp("power down off", 32'h0, {31'h0, powerDownReq});
    rdChk(pei_pkg::IDX_EVT, 32'h2020, "evt ls pin");
    repeat (2) @(posedge sys_clk);
    cmp("pin released", 32'h1, {31'h0, intPdPinOut});
    wr(pei_pkg::IDX_CTRL, 32'h5);
    repeat (2) @(posedge sys_clk);
    cmp("pin test int", 32'h0, {31'h0, intPdPinOut});
    wr(pei_pkg::IDX_CTRL, 32'h0);
    $display("test pin done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
